//--- boc_consts.vh
`ifndef BOC_CONSTS_VH
`define BOC_CONSTS_VH

// Timing base
`define BOC_CLK_PERIOD_NS 10
`define BOC_TICK_US 10000
`define BOC_TICK_CYC (`BOC_TICK_US * 1000 / `BOC_CLK_PERIOD_NS)

// Default times in ms, converted to ticks
`define BOC_TRAV_MS 200
`define BOC_SWAIT_MS 200
`define BOC_CMAX_MS 200
`define BOC_OMAX_MS 200
`define BOC_TERM_MS 10000
`define BOC_FTRIP_MS 200
`define BOC_MS2TICK(ms) ((ms) * 1000 / `BOC_TICK_US)

// Register byte offsets
`define BOC_A_CTRL 8'h00
`define BOC_A_TRAV 8'h04
`define BOC_A_SWAIT 8'h08
`define BOC_A_CMAX 8'h0c
`define BOC_A_OMAX 8'h10
`define BOC_A_TERM 8'h14
`define BOC_A_FTRIP 8'h18
`define BOC_A_PANEL 8'h1c
`define BOC_A_STAT 8'h20
`define BOC_A_FOPEN 8'h24
`define BOC_A_FCLOSE 8'h28

// Control register fields
`define BOC_F_TYPE 0
`define BOC_F_SYNC 2
`define BOC_F_RDY 3
`define BOC_F_LVL 5
`define BOC_F_SRC 7
`define BOC_F_CLR 10
`define BOC_CTRL_RST 10'h3c1

// Panel register fields
`define BOC_F_POPEN 0
`define BOC_F_PCLOSE 1
`define BOC_F_PLVL 2

// Object types
`define BOC_T_WDCB 2'h0
`define BOC_T_CB 2'h1
`define BOC_T_DISC 2'h2
`define BOC_T_EARTH 2'h3

// Ready gating modes
`define BOC_RDY_OFF 2'h0
`define BOC_RDY_HIGH 2'h1
`define BOC_RDY_LOW 2'h2

// Breaker and cart status codes
`define BOC_ST_INTER 2'h0
`define BOC_CART_INTER 3'h0
`define BOC_CART_OUT 3'h1
`define BOC_CART_IN 3'h2
`define BOC_CART_BAD 3'h3
`define BOC_CART_NONE 3'h4

`define BOC_RESP_OKAY 2'h0
`define BOC_RESP_SLVERR 2'h2

`endif

//--- boc_object.v
// Contract
// - Separate 32-bit counters of failed open and failed close requests.
// - Clear action zeroes the counters; clear bit then returns to idle itself.
// - Object type selects cart, ready, sync gating and whether control exists.
// - Open input high means open; close input high means closed.
// - Cart-in high means inserted; cart-out high means withdrawn.
// - Ready input high means spring charged, object ready to close.
// - Synchrocheck input high means synchronism met, closing permitted.
// - Separate open and close command pulse outputs.
// - Traverse time bounds transition; then report Bad or Intermediate.
// - Close waits for synchrocheck ok; cancelled after sync wait timeout.
// - Close pulse ends at max length or on detected close.
// - Open pulse ends at max length or on detected open.
// - No state change within termination timeout raises error, ends control.
// - Final trip signal lasts set length; zero length means continuous.
// - With auto-reclose, final trip only if no reclosing expected.
// - Panel control allowed only at or above the configured access level.
// - Open and close accepted from local, remote and application sources.
// - Neither position active is Intermediate; both active is Bad.
// - With sync gating, close issued only while sync input is active.
// - With ready gating, close needs ready to match configured polarity.
`timescale 1ns/1ps
`include "boc_consts.vh"

module boc_object #(
   parameter TICK_CYC = `BOC_TICK_CYC,
   parameter TW = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire pos_open_in,
   input wire pos_close_in,
   input wire cart_inserted_input,
   input wire cart_withdrawn_input,
   input wire ready_in,
   input wire sync_ok_in,
   input wire local_open_in,
   input wire local_close_in,
   input wire remote_open_in,
   input wire remote_close_in,
   input wire app_open_in,
   input wire app_close_in,
   input wire trip_done_in,
   input wire ar_more_expected_in,
   output reg open_cmd_r,
   output reg close_cmd_r,
   output reg final_trip_r,
   output reg ctrl_err_r,
   output reg [1:0] brk_status_r,
   output reg [2:0] cart_status_r
);

   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_SWAIT = 4'b0010;
   localparam [3:0] S_PULSE = 4'b0100;
   localparam [3:0] S_WAIT = 4'b1000;
   localparam integer TRAV_D = `BOC_MS2TICK(`BOC_TRAV_MS);
   localparam integer SWAIT_D = `BOC_MS2TICK(`BOC_SWAIT_MS);
   localparam integer CMAX_D = `BOC_MS2TICK(`BOC_CMAX_MS);
   localparam integer OMAX_D = `BOC_MS2TICK(`BOC_OMAX_MS);
   localparam integer TERM_D = `BOC_MS2TICK(`BOC_TERM_MS);
   localparam integer FTRIP_D = `BOC_MS2TICK(`BOC_FTRIP_MS);
   localparam [31:0] TICK_LAST = TICK_CYC - 1;
   localparam [TW-1:0] ONE = 1;
   localparam PAD = 32 - TW;

   reg [9:0] ctrl_r;
   reg clr_r;
   reg [1:0] sess_lvl_r;
   reg [TW-1:0] trav_r, swait_r, cmax_r, omax_r, term_r, ftl_r;
   reg [31:0] fail_open_r, fail_close_r;
   reg [31:0] pre_r;
   reg [TW-1:0] trav_cnt_r, st_cnt_r, term_cnt_r, ft_cnt_r;
   reg [3:0] st_r, st_nxt;
   reg dir_r, dir_nxt;
   reg inc_fo, inc_fc, err_nxt;
   reg [6:0] in_q_r;
   reg [31:0] wr_cur, rd_val;
   reg wr_hit, rd_hit;

   wire tick = (pre_r == TICK_LAST);
   wire [1:0] obj_type = ctrl_r[`BOC_F_TYPE+1:`BOC_F_TYPE];
   wire [1:0] rdy_mode = ctrl_r[`BOC_F_RDY+1:`BOC_F_RDY];
   wire [1:0] lvl_req = ctrl_r[`BOC_F_LVL+1:`BOC_F_LVL];
   wire [2:0] src_en = ctrl_r[`BOC_F_SRC+2:`BOC_F_SRC];
   wire is_brk = (obj_type == `BOC_T_WDCB) || (obj_type == `BOC_T_CB);
   wire ctl_ok = (obj_type != `BOC_T_EARTH);
   wire sync_gate = is_brk & ctrl_r[`BOC_F_SYNC];
   wire ready_ok = !is_brk || (rdy_mode == `BOC_RDY_HIGH ? ready_in :
                   rdy_mode == `BOC_RDY_LOW ? ~ready_in : 1'b1);
   wire close_ok = ctl_ok & ready_ok;
   wire [6:0] in_vec = {trip_done_in, app_close_in, app_open_in,
                        remote_close_in, remote_open_in,
                        local_close_in, local_open_in};
   wire [6:0] rise = in_vec & ~in_q_r;

   wire wr_en = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_en = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_en;
   assign s_axi_wready = wr_en;
   assign s_axi_arready = rd_en;
   wire [7:0] wa = s_axi_awaddr[7:0];

   // Byte-lane merge of a write onto the current value
   function [31:0] bmerge(input [31:0] o, input [31:0] d, input [3:0] s);
      integer i;
      begin
         bmerge = o;
         for (i = 0; i < 4; i = i + 1)
            if (s[i]) bmerge[i*8 +: 8] = d[i*8 +: 8];
      end
   endfunction

   // Reads only its arguments, so @* follows every register behind it
   function [31:0] reg_rd(input [7:0] a, input [351:0] m);
      begin
         if (a > `BOC_A_FCLOSE) reg_rd = 32'h0;
         else reg_rd = m[{a[5:2], 5'h0} +: 32];
      end
   endfunction

   function hit(input [7:0] a);
      begin
         hit = (a <= `BOC_A_FCLOSE) && (a[1:0] == 2'h0);
      end
   endfunction

   wire [31:0] stat_w = {18'h0, ~(ctl_ok), close_ok, ctl_ok, sync_ok_in,
                         ready_ok, final_trip_r, close_cmd_r, open_cmd_r,
                         ~st_r[0], cart_status_r, brk_status_r};
   // Word n of the map answers at byte offset 4n
   wire [351:0] map_w = {fail_close_r, fail_open_r, stat_w,
                         28'h0, sess_lvl_r, 2'h0, {PAD{1'b0}}, ftl_r,
                         {PAD{1'b0}}, term_r, {PAD{1'b0}}, omax_r,
                         {PAD{1'b0}}, cmax_r, {PAD{1'b0}}, swait_r,
                         {PAD{1'b0}}, trav_r, 21'h0, clr_r, ctrl_r};

   always @* begin
      wr_cur = bmerge(reg_rd(wa, map_w), s_axi_wdata, s_axi_wstrb);
      rd_val = reg_rd(s_axi_araddr[7:0], map_w);
      wr_hit = hit(wa) && (s_axi_awaddr[31:8] == 24'h0);
      rd_hit = hit(s_axi_araddr[7:0]) && (s_axi_araddr[31:8] == 24'h0);
   end

   // Panel request: write strobes, honoured only at sufficient level
   wire pnl_wr = wr_en & wr_hit & (wa == `BOC_A_PANEL);
   wire [1:0] pnl_lvl = wr_cur[`BOC_F_PLVL+1:`BOC_F_PLVL];
   wire pnl_ok = pnl_wr & (pnl_lvl >= lvl_req);
   wire pnl_open = pnl_ok & wr_cur[`BOC_F_POPEN];
   wire pnl_close = pnl_ok & wr_cur[`BOC_F_PCLOSE];
   wire req_op = (src_en[0] & rise[0]) | (src_en[1] & rise[2]) |
                 (src_en[2] & rise[4]) | pnl_open;
   wire req_cl = (src_en[0] & rise[1]) | (src_en[1] & rise[3]) |
                 (src_en[2] & rise[5]) | pnl_close;
   wire at_open = pos_open_in & ~pos_close_in;
   wire at_closed = pos_close_in & ~pos_open_in;
   wire reached = dir_r ? at_closed : at_open;

   always @* begin
      st_nxt = st_r;
      dir_nxt = dir_r;
      inc_fo = 1'b0;
      inc_fc = 1'b0;
      err_nxt = 1'b0;
      case (st_r)
         S_IDLE: begin
            // Open has priority when both arrive together
            if (req_op) begin
               if (!ctl_ok) inc_fo = 1'b1;
               else begin
                  dir_nxt = 1'b0;
                  st_nxt = S_PULSE;
               end
            end else if (req_cl) begin
               if (!close_ok) inc_fc = 1'b1;
               else begin
                  dir_nxt = 1'b1;
                  st_nxt = (sync_gate & ~sync_ok_in) ? S_SWAIT : S_PULSE;
               end
            end
         end
         S_SWAIT: begin
            if (sync_ok_in) st_nxt = S_PULSE;
            else if (st_cnt_r >= swait_r) begin
               inc_fc = 1'b1;
               st_nxt = S_IDLE;
            end
         end
         S_PULSE, S_WAIT: begin
            if (reached) st_nxt = S_IDLE;
            else if (term_cnt_r >= term_r) begin
               err_nxt = 1'b1;
               inc_fo = ~dir_r;
               inc_fc = dir_r;
               st_nxt = S_IDLE;
            end else if (st_r == S_PULSE &&
                         st_cnt_r >= (dir_r ? cmax_r : omax_r))
               st_nxt = S_WAIT;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   wire close_start = (st_nxt == S_PULSE) & dir_nxt & (st_r != S_PULSE);
   wire ft_set = rise[6] & ~ar_more_expected_in;

   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= 32'h0;
         in_q_r <= 7'h0;
         st_r <= S_IDLE;
         dir_r <= 1'b0;
         open_cmd_r <= 1'b0;
         close_cmd_r <= 1'b0;
         ctrl_err_r <= 1'b0;
         st_cnt_r <= {TW{1'b0}};
         term_cnt_r <= {TW{1'b0}};
         trav_cnt_r <= {TW{1'b0}};
         brk_status_r <= `BOC_ST_INTER;
         cart_status_r <= `BOC_CART_NONE;
         final_trip_r <= 1'b0;
         ft_cnt_r <= {TW{1'b0}};
         fail_open_r <= 32'h0;
         fail_close_r <= 32'h0;
      end else begin
         pre_r <= tick ? 32'h0 : pre_r + 32'h1;
         in_q_r <= in_vec;
         st_r <= st_nxt;
         dir_r <= dir_nxt;
         open_cmd_r <= (st_nxt == S_PULSE) & ~dir_nxt;
         close_cmd_r <= (st_nxt == S_PULSE) & dir_nxt;
         ctrl_err_r <= err_nxt;
         if (st_nxt != st_r) st_cnt_r <= {TW{1'b0}};
         else if (tick && ~&st_cnt_r) st_cnt_r <= st_cnt_r + ONE;
         // Termination time runs from the first command edge
         if (!st_r[2] && !st_r[3]) term_cnt_r <= {TW{1'b0}};
         else if (tick && ~&term_cnt_r) term_cnt_r <= term_cnt_r + ONE;
         // Status raw code {close,open} matches status encoding
         if (pos_open_in ^ pos_close_in) begin
            trav_cnt_r <= {TW{1'b0}};
            brk_status_r <= {pos_close_in, pos_open_in};
         end else begin
            if (tick && ~&trav_cnt_r) trav_cnt_r <= trav_cnt_r + ONE;
            if (trav_cnt_r >= trav_r)
               brk_status_r <= {pos_close_in, pos_open_in};
         end
         if (obj_type != `BOC_T_WDCB) cart_status_r <= `BOC_CART_NONE;
         else if (cart_inserted_input & cart_withdrawn_input)
            cart_status_r <= `BOC_CART_BAD;
         else if (cart_inserted_input) cart_status_r <= `BOC_CART_IN;
         else if (cart_withdrawn_input) cart_status_r <= `BOC_CART_OUT;
         else cart_status_r <= `BOC_CART_INTER;
         if (ft_set) begin
            final_trip_r <= 1'b1;
            ft_cnt_r <= {TW{1'b0}};
         end else if (close_start) final_trip_r <= 1'b0;
         else if (final_trip_r && ftl_r != {TW{1'b0}} && ft_cnt_r >= ftl_r)
            final_trip_r <= 1'b0;
         else if (tick && ~&ft_cnt_r) ft_cnt_r <= ft_cnt_r + ONE;
         // A failure in the clearing cycle survives as a count of one
         if (clr_r) fail_open_r <= {31'h0, inc_fo};
         else if (inc_fo && ~&fail_open_r)
            fail_open_r <= fail_open_r + 32'h1;
         if (clr_r) fail_close_r <= {31'h0, inc_fc};
         else if (inc_fc && ~&fail_close_r)
            fail_close_r <= fail_close_r + 32'h1;
      end
   end

   // Register file and bus answers
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `BOC_CTRL_RST;
         clr_r <= 1'b0;
         sess_lvl_r <= 2'h0;
         trav_r <= TRAV_D[TW-1:0];
         swait_r <= SWAIT_D[TW-1:0];
         cmax_r <= CMAX_D[TW-1:0];
         omax_r <= OMAX_D[TW-1:0];
         term_r <= TERM_D[TW-1:0];
         ftl_r <= FTRIP_D[TW-1:0];
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BOC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `BOC_RESP_OKAY;
         s_axi_rdata <= 32'h0;
      end else begin
         clr_r <= 1'b0;
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `BOC_RESP_OKAY : `BOC_RESP_SLVERR;
            if (wr_hit) begin
               case (wa)
                  `BOC_A_CTRL: begin
                     ctrl_r <= wr_cur[9:0];
                     clr_r <= wr_cur[`BOC_F_CLR];
                  end
                  `BOC_A_TRAV: trav_r <= wr_cur[TW-1:0];
                  `BOC_A_SWAIT: swait_r <= wr_cur[TW-1:0];
                  `BOC_A_CMAX: cmax_r <= wr_cur[TW-1:0];
                  `BOC_A_OMAX: omax_r <= wr_cur[TW-1:0];
                  `BOC_A_TERM: term_r <= wr_cur[TW-1:0];
                  `BOC_A_FTRIP: ftl_r <= wr_cur[TW-1:0];
                  `BOC_A_PANEL: sess_lvl_r <= pnl_lvl;
                  default: ;
               endcase
            end
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_val : 32'h0;
            s_axi_rresp <= rd_hit ? `BOC_RESP_OKAY : `BOC_RESP_SLVERR;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

endmodule // boc_object

//--- boc_object_monitor.sv
`timescale 1ns/1ps
module boc_object_monitor (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire pos_open_in,
   input wire pos_close_in,
   input wire trip_done_in,
   input wire ar_more_expected_in,
   input wire open_cmd_r,
   input wire close_cmd_r,
   input wire final_trip_r,
   input wire ctrl_err_r,
   input wire [1:0] brk_status_r
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   cmd_excl_a: assert property (!(open_cmd_r && close_cmd_r))
      else $error("both commands high");
   stat_open_a: assert property (
      $past(aresetn) && $past(pos_open_in) && !$past(pos_close_in)
      |-> brk_status_r == 2'h1) else $error("open not shown");
   stat_closed_a: assert property (
      $past(aresetn) && $past(pos_close_in) && !$past(pos_open_in)
      |-> brk_status_r == 2'h2) else $error("closed not shown");
   open_end_a: assert property (
      open_cmd_r && pos_open_in && !pos_close_in |=> !open_cmd_r)
      else $error("open pulse kept");
   close_end_a: assert property (
      close_cmd_r && pos_close_in && !pos_open_in |=> !close_cmd_r)
      else $error("close pulse kept");
   ftrip_set_a: assert property (
      $past(aresetn) && $rose(trip_done_in) && !ar_more_expected_in
      |=> final_trip_r) else $error("final trip missing");
   ftrip_hold_a: assert property (
      $past(aresetn) && $rose(trip_done_in) && ar_more_expected_in &&
      !final_trip_r |=> !final_trip_r) else $error("final trip early");
   err_pulse_a: assert property (
      ctrl_err_r |-> !open_cmd_r && !close_cmd_r ##1 !ctrl_err_r)
      else $error("error event wrong");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write answer dropped");
endmodule // boc_object_monitor

bind boc_object boc_object_monitor u_mon (.aclk(aclk),
   .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .pos_open_in(pos_open_in),
   .pos_close_in(pos_close_in), .trip_done_in(trip_done_in),
   .ar_more_expected_in(ar_more_expected_in), .open_cmd_r(open_cmd_r),
   .close_cmd_r(close_cmd_r), .final_trip_r(final_trip_r),
   .ctrl_err_r(ctrl_err_r), .brk_status_r(brk_status_r));

//--- boc_breaker_model.sv
`timescale 1ns/1ps
module boc_breaker_model #(
   parameter DLY = 30
) (
   input wire aclk,
   input wire open_cmd,
   input wire close_cmd,
   input wire stuck,
   input wire [1:0] ovr,
   output wire pos_open,
   output wire pos_close
);
   logic is_open = 1'b1;
   logic tgt = 1'b1;
   int cnt = 0;
   // Both contacts read 0 while the mechanism travels
   assign pos_open = ovr == 2'h1 || (ovr == 2'h0 && cnt == 0 && is_open);
   assign pos_close = ovr == 2'h1 || (ovr == 2'h0 && cnt == 0 && !is_open);
   always @(posedge aclk) begin
      if (cnt > 1)
         cnt <= cnt - 1;
      else if (cnt == 1) begin
         cnt <= 0;
         is_open <= tgt;
      end else if (!stuck && ((open_cmd && !is_open) ||
                              (close_cmd && is_open))) begin
         cnt <= DLY;
         tgt <= open_cmd;
      end
   end
endmodule // boc_breaker_model

//--- boc_object_bench.sv
`timescale 1ns/1ps
`include "boc_consts.vh"
module boc_object_bench;
   logic aclk = 0;
   logic aresetn = 0;
   logic [31:0] awa = 0, wd = 0, ara = 0;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, stuck = 0;
   logic rdy = 0, syn = 0, tdn = 0, more = 0, cin = 0, cout = 0;
   logic [1:0] ovr = 0, rsp;
   logic [5:0] req = 0;
   wire awr, wrd, bv, arr, rv, po, pc, oc, cc, ft, er;
   wire [1:0] bresp, rresp, bs;
   wire [2:0] cs;
   wire [31:0] rdata;
   int fails = 0, n_tests = 0, cyc = 0, errs = 0;
   always #5 aclk = ~aclk;
   boc_object #(.TICK_CYC(10)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .pos_open_in(po),
      .pos_close_in(pc), .cart_inserted_input(cin),
      .cart_withdrawn_input(cout), .ready_in(rdy), .sync_ok_in(syn),
      .local_open_in(req[0]), .local_close_in(req[1]),
      .remote_open_in(req[2]), .remote_close_in(req[3]),
      .app_open_in(req[4]), .app_close_in(req[5]), .trip_done_in(tdn),
      .ar_more_expected_in(more), .open_cmd_r(oc), .close_cmd_r(cc),
      .final_trip_r(ft), .ctrl_err_r(er), .brk_status_r(bs),
      .cart_status_r(cs));
   boc_breaker_model #(.DLY(30)) brk (.aclk(aclk), .open_cmd(oc),
      .close_cmd(cc), .stuck(stuck), .ovr(ovr), .pos_open(po),
      .pos_close(pc));
   task results;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Error events are one cycle wide, so they are tallied here
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (er === 1'b1)
         errs <= errs + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         results;
      end
   end
   task chk(input string n, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task cy(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= {24'h0, a};
      wd <= d;
      awv <= 1;
      wv <= 1;
      do @(posedge aclk); while (!(awr && wrd));
      awv <= 0;
      wv <= 0;
      // Late bready makes the slave hold its answer a cycle
      @(posedge aclk);
      br <= 1;
      do @(posedge aclk); while (!bv);
      rsp = bresp;
      br <= 0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge aclk);
      ara <= {24'h0, a};
      arv <= 1;
      rr <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      do @(posedge aclk); while (!rv);
      rsp = rresp;
      rr <= 0;
      chk(n, e, rdata);
   endtask
   task rq(input int b);
      @(posedge aclk);
      req[b] <= 1;
      cy(2);
      req[b] <= 0;
   endtask
   task t_dflt;
      rc(`BOC_A_CTRL, 32'h3c1, "ctrl");
      rc(`BOC_A_TRAV, 32'h14, "trav");
      rc(`BOC_A_TERM, 32'h3e8, "term");
      rc(`BOC_A_FOPEN, 32'h0, "fopen");
      rc(8'h2c, 32'h0, "unmapped");
      chk("rresp", `BOC_RESP_SLVERR, rsp);
      wr(8'h2c, 32'h0);
      chk("bresp", `BOC_RESP_SLVERR, rsp);
      rc(`BOC_A_STAT, 32'h1a11, "stat");
      chk("brk", 32'h1, bs);
      chk("cart", 32'h4, cs);
   endtask
   task t_move;
      rq(3);
      chk("remote close", 32'h1, cc);
      cy(80);
      chk("close early end", 32'h0, cc);
      chk("closed", 32'h2, bs);
      rq(0);
      chk("local open", 32'h1, oc);
      cy(80);
      chk("open early end", 32'h0, oc);
      chk("opened", 32'h1, bs);
   endtask
   task t_gate;
      wr(`BOC_A_CTRL, 32'h3c9);
      rq(5);
      chk("ready refuse", 32'h0, cc);
      rc(`BOC_A_FCLOSE, 32'h1, "fclose");
      wr(`BOC_A_CTRL, 32'h3cd);
      rdy <= 1;
      rq(1);
      cy(250);
      chk("sync cancel", 32'h0, cc);
      rc(`BOC_A_FCLOSE, 32'h2, "fclose");
      rq(1);
      cy(20);
      chk("sync wait", 32'h0, cc);
      syn <= 1;
      cy(3);
      chk("sync close", 32'h1, cc);
      cy(80);
      chk("closed", 32'h2, bs);
   endtask
   task t_term;
      wr(`BOC_A_OMAX, 32'h2);
      wr(`BOC_A_TERM, 32'h5);
      stuck <= 1;
      rq(4);
      chk("app open", 32'h1, oc);
      cy(40);
      chk("open max", 32'h0, oc);
      cy(40);
      chk("term err", 32'h1, errs);
      rc(`BOC_A_FOPEN, 32'h1, "fopen");
      stuck <= 0;
      wr(`BOC_A_OMAX, 32'h14);
      rq(0);
      cy(80);
      chk("opened", 32'h1, bs);
   endtask
   task t_types;
      wr(`BOC_A_CTRL, 32'h3c3);
      rq(2);
      chk("earth refuse", 32'h0, oc);
      rc(`BOC_A_FOPEN, 32'h2, "fopen");
      wr(`BOC_A_CTRL, 32'h3c0);
      cin <= 1;
      cy(3);
      chk("cart in", 32'h2, cs);
      cin <= 0;
      cout <= 1;
      cy(3);
      chk("cart out", 32'h1, cs);
      cin <= 1;
      cy(3);
      chk("cart bad", 32'h3, cs);
      cin <= 0;
      cout <= 0;
      cy(3);
      chk("cart inter", 32'h0, cs);
      wr(`BOC_A_CTRL, 32'h3c1);
      cy(2);
      chk("no cart", 32'h4, cs);
   endtask
   task t_clr;
      wr(`BOC_A_CTRL, 32'h7c1);
      rc(`BOC_A_CTRL, 32'h3c1, "clear idle");
      rc(`BOC_A_FOPEN, 32'h0, "fopen");
      rc(`BOC_A_FCLOSE, 32'h0, "fclose");
   endtask
   task t_trip;
      more <= 1;
      tdn <= 1;
      cy(3);
      chk("reclose due", 32'h0, ft);
      tdn <= 0;
      more <= 0;
      cy(2);
      tdn <= 1;
      cy(3);
      chk("ftrip on", 32'h1, ft);
      cy(170);
      chk("ftrip len", 32'h1, ft);
      cy(60);
      chk("ftrip off", 32'h0, ft);
      tdn <= 0;
      wr(`BOC_A_FTRIP, 32'h0);
      tdn <= 1;
      cy(300);
      chk("ftrip steady", 32'h1, ft);
      tdn <= 0;
   endtask
   task t_panel;
      wr(`BOC_A_PANEL, 32'h6);
      cy(2);
      chk("level low", 32'h0, cc);
      wr(`BOC_A_PANEL, 32'ha);
      chk("panel close", 32'h1, cc);
      chk("ftrip cleared", 32'h0, ft);
      cy(80);
      chk("closed", 32'h2, bs);
   endtask
   task t_bad;
      ovr <= 2'h1;
      cy(50);
      chk("held", 32'h2, bs);
      cy(250);
      chk("bad", 32'h3, bs);
      ovr <= 2'h2;
      cy(300);
      chk("inter", 32'h0, bs);
      ovr <= 2'h0;
      cy(3);
      chk("closed", 32'h2, bs);
   endtask
   initial begin
      cy(4);
      aresetn <= 1;
      cy(1);
      t_dflt;
      t_move;
      t_gate;
      t_term;
      t_types;
      t_clr;
      t_trip;
      t_panel;
      t_bad;
      results;
   end
endmodule // boc_object_bench
